/* File: bench/amv_producer.sv */
// Macroblock producer model: one macroblock per request, random references.
// Assumes core_clk from the bench; outputs change only at rising edges.
module amv_producer
    import amv_pkg::*;
#(
    parameter int IDX_W = 8
) (
    input  wire logic                   core_clk,
    input  wire logic                   req,
    input  wire logic [5:0]             kind,
    output logic                        mb_valid,
    output logic [5:0]                  mb_kind,
    output logic [3:0][1:0]             shape,
    output logic [3:0][1:0]             dir,
    output logic [15:0][IDX_W-1:0]      r0,
    output logic [15:0][IDX_W-1:0]      r1,
    output logic [15:0]                 p0,
    output logic [15:0]                 p1
);
    timeunit 1ns;
    timeprecision 1ps;
    integer     seed = 32'hE322;
    int         ftab [9] = '{0, 1, 0, 1, 0, 1, 2, 2, 2};
    int         stab [9] = '{0, 1, 1, 0, 2, 2, 0, 1, 2};
    logic [31:0] v;
    logic [31:0] w;
    logic [1:0]  a;
    logic [1:0]  b;

    initial begin
        {mb_valid, mb_kind, shape, dir} = '0;
        {r0, r1, p0, p1} = '0;
    end

    // References differ across sub-blocks on purpose, so a wrong pick shows.
    always @(posedge core_clk) begin
        v = $random(seed);
        w = $random(seed);
        mb_valid <= req;
        mb_kind <= kind;
        for (int i = 0; i < 16; i++) begin
            r0[i] <= IDX_W'($random(seed));
            r1[i] <= IDX_W'($random(seed));
        end
        p0 <= w[15:0];
        p1 <= ~w[15:0] | w[31:16];
        shape <= '0;
        dir <= '0;
        if (kind >= KIND_L0_16X16 && kind <= KIND_BI_16X16) begin
            dir <= {4{kind[1:0] - 2'h1}};
        end else if (kind >= KIND_TWO_FIRST && kind <= KIND_TWO_LAST) begin
            a = 2'(ftab[(kind - 6'h04) >> 1]);
            b = 2'(stab[(kind - 6'h04) >> 1]);
            dir <= kind[0] ? {b, a, b, a} : {b, b, a, a};
        end else if (kind == KIND_QUAD_SPLIT) begin
            shape <= v[0] ? 8'h00 : (v[15:8] == 8'h00 ? 8'h03 : v[15:8]);
            for (int q = 0; q < 4; q++) begin
                dir[q] <= (v[1] && (2'(q) == v[5:4] || v[q + 28])) ?
                          DIR_BI : {1'b0, v[q + 24]};
            end
        end
    end
endmodule : amv_producer

/* File: bench/tb_amv_map.sv */
// Testbench for the mapper: a reference model predicts every output.
// Assumes the producer model drives all macroblock inputs of the mapper.
module tb_amv_map
    import amv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IW = 8;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic req = 1'b0;
    logic [5:0] kind = 6'h00;
    logic mb_valid, reserved_kind_ff, result_valid_ff;
    logic [5:0] mb_kind, vector_count_class_ff, extracted_count_ff;
    logic [3:0][1:0] shape, dir;
    logic [15:0][IW-1:0] ref_l0, ref_l1;
    logic [15:0] p0, p1;
    amv_state_t combined_vector_state_ff, exp_state = AMV_B0;
    logic [3:0][IW-1:0] fwd_index_ff, bwd_index_ff, ef = '0, eb = '0;
    logic [5:0] exp_class = 6'h00, exp_count = 6'h00;
    logic exp_res = 1'b0, exp_valid = 1'b0, armed = 1'b0;
    int n_mismatch = 0, check_count = 0, cycles = 0;
    int ord [4] = '{1, 0, 3, 2};

    amv_producer #(.IDX_W(IW)) prod (.core_clk(core_clk), .req(req),
        .kind(kind), .mb_valid(mb_valid), .mb_kind(mb_kind), .shape(shape),
        .dir(dir), .r0(ref_l0), .r1(ref_l1), .p0(p0), .p1(p1));
    amv_map #(.IDX_W(IW)) dut (.core_clk(core_clk), .nrst(nrst),
        .mb_valid(mb_valid), .macroblock_partition_kind(mb_kind),
        .sub_block_shape(shape), .sub_block_prediction_dir(dir),
        .ref_l0(ref_l0), .ref_l1(ref_l1), .sub_l0_present(p0),
        .sub_l1_present(p1),
        .combined_vector_state_ff(combined_vector_state_ff),
        .vector_count_class_ff(vector_count_class_ff),
        .extracted_count_ff(extracted_count_ff),
        .fwd_index_ff(fwd_index_ff), .bwd_index_ff(bwd_index_ff),
        .result_valid_ff(result_valid_ff),
        .reserved_kind_ff(reserved_kind_ff));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [IW-1:0] pick(int s, logic fw, logic [1:0] d);
        if (fw) return (d == DIR_L1) ? ref_l1[s] : ref_l0[s];
        return (d == DIR_L0) ? ref_l0[s] : ref_l1[s];
    endfunction : pick

    task automatic model();
        int cnt, s, m;
        logic bi, sub, hf, hb;
        exp_state = AMV_B0;
        {exp_class, ef, eb, exp_res, bi, sub, cnt} = '0;
        for (int q = 0; q < 4; q++) begin
            bi |= (dir[q] == DIR_BI);
            sub |= (shape[q] != SHAPE_8X8);
        end
        if (mb_kind >= KIND_L0_16X16 && mb_kind <= KIND_TWO_LAST) begin
            exp_state = mb_kind <= KIND_BI_16X16 ? AMV_B1 : AMV_B2;
            exp_class = mb_kind <= KIND_BI_16X16 ? CLASS_B1 : CLASS_B2;
        end else if (mb_kind == KIND_QUAD_SPLIT) begin
            exp_state = sub ? (bi ? AMV_B3 : AMV_P3) : AMV_B2;
            exp_class = sub ? (bi ? CLASS_B3 : CLASS_P3) : CLASS_B2;
        end else begin
            exp_res = 1'b1;
        end
        for (int q = 0; q < 4 && !exp_res; q++) begin
            m = (dir[q] == DIR_BI) ? 2 : 1;
            if (mb_kind <= KIND_BI_16X16) begin
                s = 0;
                cnt = (q == 0) ? m : cnt;
            end else if (mb_kind <= KIND_TWO_LAST) begin
                s = (mb_kind[0] ? q % 2 : q / 2) * (mb_kind[0] ? 4 : 8);
                cnt += (q == 0 || q == 3) ? m : 0;
            end else begin
                s = q * 4;
                cnt += m * (shape[q] == 2'h3 ? 4 : (shape[q] != 0 ? 2 : 1));
            end
            ef[q] = pick(s, 1'b1, dir[q]);
            eb[q] = pick(s, 1'b0, dir[q]);
            if (mb_kind == KIND_QUAD_SPLIT && sub) begin
                {hf, hb, ef[q], eb[q]} = '0;
                for (int k = 0; k < 4; k++) begin
                    s = q * 4 + ord[k];
                    if (!hf && p0[s]) ef[q] = ref_l0[s];
                    if (!hb && p1[s]) eb[q] = ref_l1[s];
                    hf |= p0[s];
                    hb |= p1[s];
                end
                if (!hb) eb[q] = ef[q];
                if (!hf) ef[q] = eb[q];
            end
        end
        exp_count = 6'(cnt);
    endtask : model

    always @(posedge core_clk) begin
        armed = 1'b1;
        exp_valid = nrst && mb_valid;
        if (!nrst) begin
            exp_state = AMV_B0;
            {exp_class, exp_count, ef, eb, exp_res} = '0;
        end else if (mb_valid) begin
            model();
        end
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        check_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    // Every output is compared each cycle, so holding between results counts.
    always @(negedge core_clk) begin
        if (armed) begin
            check(64'(combined_vector_state_ff), 64'(exp_state));
            check(64'(vector_count_class_ff), 64'(exp_class));
            check(64'(extracted_count_ff), 64'(exp_count));
            check(64'(fwd_index_ff), 64'(ef));
            check(64'(bwd_index_ff), 64'(eb));
            check(64'(result_valid_ff), 64'(exp_valid));
            check(64'(reserved_kind_ff), 64'(exp_res));
        end
    end

    task automatic send(input logic [5:0] k);
        req <= 1'b1;
        kind <= k;
        @(posedge core_clk);
    endtask : send

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        for (int k = 0; k < 64; k++) send(6'(k));
        repeat (300) send(KIND_QUAD_SPLIT);
        // Reset lands in mid-stream to prove macroblocks arriving during it are dropped.
        nrst <= 1'b0;
        repeat (3) send(KIND_QUAD_SPLIT);
        nrst <= 1'b1;
        for (int k = 0; k < 200; k++) send(6'((k * 7) % 23));
        req <= 1'b0;
        repeat (4) @(posedge core_clk);
        results();
    end
endmodule : tb_amv_map

/* File: logic/amv_map.sv */
// Per-macroblock mapper: combined vector state, vector count class,
// extracted vector count and the eight inline binding table indices.
// Assumes inputs come from logic on core_clk and are valid with mb_valid.
module amv_map
    import amv_pkg::*;
#(
    parameter int IDX_W = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic                  mb_valid,
    input  wire logic [5:0]            macroblock_partition_kind,
    input  wire logic [3:0][1:0]       sub_block_shape,
    input  wire logic [3:0][1:0]       sub_block_prediction_dir,
    input  wire logic [15:0][IDX_W-1:0] ref_l0,
    input  wire logic [15:0][IDX_W-1:0] ref_l1,
    input  wire logic [15:0]           sub_l0_present,
    input  wire logic [15:0]           sub_l1_present,
    output amv_state_t                 combined_vector_state_ff,
    output logic [5:0]                 vector_count_class_ff,
    output logic [5:0]                 extracted_count_ff,
    output logic [3:0][IDX_W-1:0]      fwd_index_ff,
    output logic [3:0][IDX_W-1:0]      bwd_index_ff,
    output logic                       result_valid_ff,
    output logic                       reserved_kind_ff
);

    amv_state_t              nxt_state;
    logic [5:0]              nxt_class;
    logic [5:0]              nxt_count;
    logic [3:0][IDX_W-1:0]   nxt_fwd;
    logic [3:0][IDX_W-1:0]   nxt_bwd;
    logic                    nxt_reserved;

    logic                    any_subdiv;
    logic                    any_bi;
    logic [3:0][IDX_W-1:0]   scan_fwd;
    logic [3:0][IDX_W-1:0]   scan_bwd;
    logic [3:0][IDX_W-1:0]   flat_fwd;
    logic [3:0][IDX_W-1:0]   flat_bwd;
    logic [3:0][3:0]         quad_parts;
    logic [3:0][3:0]         quad_vecs;

    // Per-quadrant searches; sub-block 0 of each quadrant carries the
    // reference for 8x8 and larger partitions.
    genvar q;
    generate
        for (q = 0; q < 4; q++) begin : g_quad
            logic             has_f;
            logic             has_b;
            logic [IDX_W-1:0] f_idx;
            logic [IDX_W-1:0] b_idx;
            logic [1:0]       dir;
            logic [1:0]       sub;
            logic [3:0]       pos;

            assign dir = sub_block_prediction_dir[q];

            // Scan starts at the upper right so it wins when all agree.
            always_comb begin
                has_f = 1'b0;
                has_b = 1'b0;
                f_idx = '0;
                b_idx = '0;
                sub   = '0;
                pos   = '0;
                for (int k = 0; k < 4; k++) begin
                    sub = SUB_UPPER_RIGHT ^ k[1:0];
                    pos = {q[1:0], sub};
                    if (!has_f && sub_l0_present[pos]) begin
                        has_f = 1'b1;
                        f_idx = ref_l0[pos];
                    end
                    if (!has_b && sub_l1_present[pos]) begin
                        has_b = 1'b1;
                        b_idx = ref_l1[pos];
                    end
                end
                // A missing direction copies the one that exists.
                scan_fwd[q] = has_f ? f_idx : b_idx;
                scan_bwd[q] = has_b ? b_idx : f_idx;
            end

            // One vector pair per quadrant, direction from the mode.
            always_comb begin
                flat_fwd[q] = (dir == DIR_L1) ? ref_l1[{q[1:0], 2'h0}]
                                              : ref_l0[{q[1:0], 2'h0}];
                flat_bwd[q] = (dir == DIR_L0) ? ref_l0[{q[1:0], 2'h0}]
                                              : ref_l1[{q[1:0], 2'h0}];
            end

            always_comb begin
                case (sub_block_shape[q])
                    SHAPE_8X8: quad_parts[q] = 4'h1;
                    SHAPE_8X4: quad_parts[q] = 4'h2;
                    SHAPE_4X8: quad_parts[q] = 4'h2;
                    default:   quad_parts[q] = 4'h4;
                endcase
                quad_vecs[q] = (dir == DIR_BI) ? {quad_parts[q][2:0], 1'b0}
                                               : quad_parts[q];
            end
        end
    endgenerate

    always_comb begin
        any_subdiv = 1'b0;
        any_bi     = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (sub_block_shape[i] != SHAPE_8X8) begin
                any_subdiv = 1'b1;
            end
            if (sub_block_prediction_dir[i] == DIR_BI) begin
                any_bi = 1'b1;
            end
        end
    end

    // Two-partition helpers: odd kinds are the left/right (8x16) split.
    logic             split_vert;
    logic [1:0]       first_dir;
    logic [1:0]       second_dir;
    logic [1:0]       second_q;
    logic [IDX_W-1:0] p1_fwd;
    logic [IDX_W-1:0] p1_bwd;
    logic [IDX_W-1:0] p2_fwd;
    logic [IDX_W-1:0] p2_bwd;

    always_comb begin
        split_vert = macroblock_partition_kind[0];
        second_q   = split_vert ? 2'h1 : 2'h2;
        first_dir  = sub_block_prediction_dir[0];
        second_dir = sub_block_prediction_dir[second_q];
        p1_fwd = (first_dir == DIR_L1) ? ref_l1[0] : ref_l0[0];
        p1_bwd = (first_dir == DIR_L0) ? ref_l0[0] : ref_l1[0];
        p2_fwd = (second_dir == DIR_L1) ? ref_l1[{second_q, 2'h0}]
                                        : ref_l0[{second_q, 2'h0}];
        p2_bwd = (second_dir == DIR_L0) ? ref_l0[{second_q, 2'h0}]
                                        : ref_l1[{second_q, 2'h0}];
    end

    logic [5:0] quad_sum;

    always_comb begin
        quad_sum = 6'(quad_vecs[0]) + 6'(quad_vecs[1])
                 + 6'(quad_vecs[2]) + 6'(quad_vecs[3]);
    end

    always_comb begin
        nxt_state    = AMV_B0;
        nxt_class    = CLASS_B0;
        nxt_count    = 6'h00;
        nxt_fwd      = '0;
        nxt_bwd      = '0;
        nxt_reserved = 1'b0;
        if (macroblock_partition_kind >= KIND_L0_16X16 &&
            macroblock_partition_kind <= KIND_BI_16X16) begin
            nxt_state = AMV_B1;
            nxt_class = CLASS_B1;
            case (macroblock_partition_kind)
                KIND_L0_16X16: begin
                    nxt_count = 6'h01;
                    nxt_fwd   = {4{ref_l0[0]}};
                    nxt_bwd   = {4{ref_l0[0]}};
                end
                KIND_L1_16X16: begin
                    nxt_count = 6'h01;
                    nxt_fwd   = {4{ref_l1[0]}};
                    nxt_bwd   = {4{ref_l1[0]}};
                end
                default: begin
                    nxt_count = 6'h02;
                    nxt_fwd   = {4{ref_l0[0]}};
                    nxt_bwd   = {4{ref_l1[0]}};
                end
            endcase
        end else if (macroblock_partition_kind >= KIND_TWO_FIRST &&
                     macroblock_partition_kind <= KIND_TWO_LAST) begin
            nxt_state = AMV_B2;
            nxt_class = CLASS_B2;
            nxt_count = ((first_dir == DIR_BI) ? 6'h02 : 6'h01)
                      + ((second_dir == DIR_BI) ? 6'h02 : 6'h01);
            // Each partition is copied to both quadrants it covers.
            if (split_vert) begin
                nxt_fwd = {p2_fwd, p1_fwd, p2_fwd, p1_fwd};
                nxt_bwd = {p2_bwd, p1_bwd, p2_bwd, p1_bwd};
            end else begin
                nxt_fwd = {p2_fwd, p2_fwd, p1_fwd, p1_fwd};
                nxt_bwd = {p2_bwd, p2_bwd, p1_bwd, p1_bwd};
            end
        end else if (macroblock_partition_kind == KIND_QUAD_SPLIT) begin
            nxt_count = quad_sum;
            if (!any_subdiv) begin
                nxt_state = AMV_B2;
                nxt_class = CLASS_B2;
                nxt_fwd   = flat_fwd;
                nxt_bwd   = flat_bwd;
            end else begin
                nxt_state = any_bi ? AMV_B3 : AMV_P3;
                nxt_class = any_bi ? CLASS_B3 : CLASS_P3;
                nxt_fwd   = scan_fwd;
                nxt_bwd   = scan_bwd;
            end
        end else begin
            // Kind 0 and kinds above the quad split carry no vectors.
            nxt_reserved = 1'b1;
        end
    end

    // Outputs other than result_valid_ff hold the last accepted macroblock until the next one.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            combined_vector_state_ff <= AMV_B0;
            vector_count_class_ff    <= CLASS_B0;
            extracted_count_ff       <= 6'h00;
            reserved_kind_ff         <= 1'b0;
        end else if (mb_valid) begin
            combined_vector_state_ff <= nxt_state;
            vector_count_class_ff    <= nxt_class;
            extracted_count_ff       <= nxt_count;
            reserved_kind_ff         <= nxt_reserved;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fwd_index_ff <= '0;
            bwd_index_ff <= '0;
        end else if (mb_valid) begin
            fwd_index_ff <= nxt_fwd;
            bwd_index_ff <= nxt_bwd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            result_valid_ff <= 1'b0;
        end else begin
            result_valid_ff <= mb_valid;
        end
    end

    // Checks on the registered result against the accepted inputs. A
    // macroblock is only taken while nrst is high, so each mb_valid trigger asks for
    // it too; otherwise the edge that releases reset would look like a take.
    state_class_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        result_valid_ff |->
        (combined_vector_state_ff == AMV_B0 && vector_count_class_ff == 6'h00)
     || (combined_vector_state_ff == AMV_B1 && vector_count_class_ff == 6'h02)
     || (combined_vector_state_ff == AMV_B2 && vector_count_class_ff == 6'h08)
     || (combined_vector_state_ff == AMV_P3 && vector_count_class_ff == 6'h10)
     || (combined_vector_state_ff == AMV_B3 && vector_count_class_ff == 6'h20))
        else $error("state and count class disagree");

    valid_pulse_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid |=> result_valid_ff)
        else $error("result valid did not follow input");

    single_kind_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid && macroblock_partition_kind == 6'h01 |=>
        combined_vector_state_ff == AMV_B1
        && fwd_index_ff == {4{$past(ref_l0[0])}}
        && bwd_index_ff == {4{$past(ref_l0[0])}})
        else $error("L0 16x16 indices not replicated");

    bi_single_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid && macroblock_partition_kind == 6'h03 |=>
        fwd_index_ff == {4{$past(ref_l0[0])}}
        && bwd_index_ff == {4{$past(ref_l1[0])}})
        else $error("bi 16x16 indices wrong");

    // The split direction is that of the taken macroblock, not the next one.
    two_part_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid && macroblock_partition_kind >= 6'h04
        && macroblock_partition_kind <= 6'h15 |=>
        combined_vector_state_ff == AMV_B2
        && vector_count_class_ff == 6'h08
        && fwd_index_ff[0]
           == fwd_index_ff[$past(macroblock_partition_kind[0]) ? 2 : 1]
        && bwd_index_ff[0]
           == bwd_index_ff[$past(macroblock_partition_kind[0]) ? 2 : 1]
        && fwd_index_ff[3]
           == fwd_index_ff[$past(macroblock_partition_kind[0]) ? 1 : 2]
        && bwd_index_ff[3]
           == bwd_index_ff[$past(macroblock_partition_kind[0]) ? 1 : 2])
        else $error("two-partition copy wrong");

    quad_flat_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid && macroblock_partition_kind == 6'h16
        && sub_block_shape == '0 && !any_bi |=>
        combined_vector_state_ff == AMV_B2 && extracted_count_ff == 6'h04)
        else $error("flat quad split without bi wrong");

    quad_flat_bi_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid && macroblock_partition_kind == 6'h16
        && !any_subdiv && any_bi |=>
        combined_vector_state_ff == AMV_B2
        && vector_count_class_ff == 6'h08
        && extracted_count_ff >= 6'h05 && extracted_count_ff <= 6'h08)
        else $error("flat quad split with bi wrong");

    quad_p3_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid && macroblock_partition_kind == 6'h16
        && any_subdiv && !any_bi |=>
        combined_vector_state_ff == AMV_P3
        && extracted_count_ff >= 6'h05 && extracted_count_ff <= 6'h10)
        else $error("subdivided quad split state wrong");

    quad_b3_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && mb_valid && macroblock_partition_kind == 6'h16
        && any_subdiv && any_bi |=>
        combined_vector_state_ff == AMV_B3
        && extracted_count_ff >= 6'h06 && extracted_count_ff <= 6'h20)
        else $error("subdivided bi quad split state wrong");

    hold_result_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        !mb_valid |=> $stable(fwd_index_ff) && $stable(bwd_index_ff))
        else $error("indices changed without a macroblock");

endmodule : amv_map

/* File: logic/amv_pkg.sv */
// Constants, encodings and state types for the vector state and binding
// index mapper. Assumes a single clock domain and no register bus.
// How it works
// - Quad split, no subdivision, no bi: B2, class 8, four vectors.
// - Quad split, no subdivision, some bi: B2, class 8, 5-8 vectors.
// - Quad split, subdivided, no bi: P3, class 16, 5-16 vectors.
// - Quad split, subdivided, some bi: B3, class 32, 6-32 vectors.
// - Every inter macroblock yields four forward and four backward indices.
// - Below 8x8, the quadrant index comes from the first present sub-block, upper right first.
// - A partition above 8x8 copies its index into every covered quadrant.
// - A missing direction takes copies of the present direction's index.
// - Kinds 1,2 copy one index everywhere; kind 3 splits L0 fwd, L1 bwd.
// - 16x8 first part covers 0,1; 8x16 covers 0,2; second takes the rest.
// - Bi second 16x8 part: L0 to forward 2,3, L1 to backward 2,3.
// - Bi first 16x8 part: L0 to forward 0,1, L1 to backward 0,1.
// - Class 8 quad split takes indices straight from vector references.
// - Class 16 scans four vectors: first forward and first backward found.
// - Class 16 with no backward vector uses the forward index as default.
// - Class 32 searches both directions and copies whichever exists.
// - States B0,B1,B2,P3,B3 mean classes 0,2,8,16,32.
package amv_pkg;

    typedef enum logic [2:0] {
        AMV_B0 = 3'b000,
        AMV_B1 = 3'b001,
        AMV_B2 = 3'b010,
        AMV_P3 = 3'b011,
        AMV_B3 = 3'b100
    } amv_state_t;

    localparam logic [5:0] CLASS_B0 = 6'h00;
    localparam logic [5:0] CLASS_B1 = 6'h02;
    localparam logic [5:0] CLASS_B2 = 6'h08;
    localparam logic [5:0] CLASS_P3 = 6'h10;
    localparam logic [5:0] CLASS_B3 = 6'h20;

    localparam logic [5:0] KIND_L0_16X16   = 6'h01;
    localparam logic [5:0] KIND_L1_16X16   = 6'h02;
    localparam logic [5:0] KIND_BI_16X16   = 6'h03;
    localparam logic [5:0] KIND_TWO_FIRST  = 6'h04;
    localparam logic [5:0] KIND_TWO_LAST   = 6'h15;
    localparam logic [5:0] KIND_QUAD_SPLIT = 6'h16;

    localparam logic [1:0] DIR_L0 = 2'h0;
    localparam logic [1:0] DIR_L1 = 2'h1;
    localparam logic [1:0] DIR_BI = 2'h2;

    localparam logic [1:0] SHAPE_8X8  = 2'h0;
    localparam logic [1:0] SHAPE_8X4  = 2'h1;
    localparam logic [1:0] SHAPE_4X8  = 2'h2;

    // Upper right 4x4 of a quadrant, raster order within the quadrant.
    localparam logic [1:0] SUB_UPPER_RIGHT = 2'h1;

endpackage : amv_pkg
